/* src/fdod_consts.vh */
// constants for the format defect option decoder
// assumes byte-wide command and header fields presented on plain ports
`ifndef FDOD_CONSTS_VH
`define FDOD_CONSTS_VH
`define FDOD_OPCODE_FORMAT     8'h04
`define FDOD_OPT_HI            4
`define FDOD_OPT_LO            2
`define FDOD_OPT_EXISTING      3'h0
`define FDOD_OPT_PROV_ONLY     3'h6
`define FDOD_OPT_PROV_EXIST    3'h4
`define FDOD_HDR_VALID_BIT     7
`define FDOD_HDR_SKIPP_BIT     6
`define FDOD_HDR_SKIPC_BIT     5
`define FDOD_HDR_HALT_BIT      4
`define FDOD_LAST_VU_HI        7
`define FDOD_LAST_VU_LO        6
`define FDOD_LAST_RSV_HI       5
`define FDOD_LAST_RSV_LO       2
`define FDOD_FLAG_BIT          1
`define FDOD_LINK_BIT          0
// grown list actions
`define FDOD_ACT_KEEP          2'h0
`define FDOD_ACT_REPLACE       2'h1
`define FDOD_ACT_MERGE         2'h2
// values held by the list choices out of reset
`define FDOD_MAP_RESET         1'b1
`define FDOD_GROWN_RESET       1'b1
`endif

/* src/fdod_decoder.v */
// format defect option decoder: command byte and header byte decode
// assumes command bytes and header byte are given with same-clock strobes
//
// Operation
// - cdb option bits 000: keep factory and grown, no data-out phase expected.
// - option bits 110 with header valid and skip-primary set: provided defects only.
// - header upper bits zero with provided defects: replace grown list.
// - valid and skip-primary set with provided defects: replace grown list.
// - option bits 100 with header upper bits zero: merge into grown list.
// - header option bits honoured only when options-valid is one.
// - skip-primary set excludes factory map, clear includes it.
`timescale 1ns/1ps
`include "fdod_consts.vh"
module fdod_decoder (
    input  wire       ref_clk,
    input  wire       arst_n,
    input  wire       cmd_valid,
    input  wire [7:0] cmd_opcode,
    input  wire [7:0] cmd_byte1,
    input  wire [7:0] cmd_last,
    input  wire       hdr_valid,
    input  wire [7:0] hdr_byte1,
    output reg        is_format,
    output reg        data_out_expected,
    output reg        last_byte_error,
    output reg        flag_bit,
    output reg        link_bit,
    output reg        hdr_done,
    output reg        use_factory_map,
    output reg        use_grown_list,
    output reg  [1:0] grown_action,
    output reg        halt_format_flag,
    output reg        skip_certification,
    output reg        hdr_mismatch
);


    // --------------------------------------------------------------
    // usage notes
    // --------------------------------------------------------------
    // a header that arrives in the same cycle as a new command is
    // judged against the previous command, since the option field
    // is only latched at that edge; the initiator keeps them apart.
    // option codes other than the three handled here still open a
    // data-out phase, but flag hdr_mismatch and keep the grown list.
    // halt and certification bits are passed through when options-valid is one; the
    // drive side decides whether it acts on them.
    // every output is registered and holds until its next update,
    // except hdr_done, which is a one-cycle strobe.
    // reset values of the list choices come from the constants header,
    // so the drive starts out managing both factory and grown lists.

    // --------------------------------------------------------------
    // decode helpers
    // --------------------------------------------------------------
    // true when the opcode byte names the format command
    function fmt_opcode;
        input [7:0] op;
        begin
            fmt_opcode = (op == `FDOD_OPCODE_FORMAT);
        end
    endfunction

    // defect-option field out of command byte 1
    function [2:0] opt_field;
        input [7:0] b1;
        begin
            opt_field = b1[`FDOD_OPT_HI:`FDOD_OPT_LO];
        end
    endfunction

    // vendor or reserved bits set in the last command byte
    function last_bad;
        input [7:0] lb;
        begin
            last_bad = (|lb[`FDOD_LAST_VU_HI:`FDOD_LAST_VU_LO]) |
                       (|lb[`FDOD_LAST_RSV_HI:`FDOD_LAST_RSV_LO]);
        end
    endfunction

    // --------------------------------------------------------------
    // internal state and next values
    // --------------------------------------------------------------
    reg  [2:0] opt;                     // option field of the last command
    reg        next_use_factory_map;    // map choice from the header
    reg        next_skip_certification; // certification choice from the header
    reg        next_halt_format_flag;   // halt choice from the header
    reg        next_use_grown_list;     // grown list kept or dropped
    reg  [1:0] next_grown_action;       // what the descriptors do to the grown list
    reg        next_hdr_mismatch;       // header met an option code not handled here
    wire       cmd_fmt;                 // command this cycle is a format
    wire [2:0] cmd_opt;                 // option field of the command this cycle
    wire       keep_cmd;                // format keeping existing lists, no data-out
    wire       hdr_take;                // header accepted this cycle
    wire       hdr_fov;                 // header options-valid bit
    wire       hdr_skipp;               // header skip-primary bit

    // --------------------------------------------------------------
    // combinational decode of the inputs
    // --------------------------------------------------------------
    // command qualifiers
    assign cmd_fmt   = cmd_valid & fmt_opcode(cmd_opcode);
    assign cmd_opt   = opt_field(cmd_byte1);
    assign keep_cmd  = cmd_fmt & (cmd_opt == `FDOD_OPT_EXISTING);
    // a header only counts after a command that expects a data-out phase
    assign hdr_take  = hdr_valid & data_out_expected;
    assign hdr_fov   = hdr_byte1[`FDOD_HDR_VALID_BIT];
    assign hdr_skipp = hdr_byte1[`FDOD_HDR_SKIPP_BIT];

    // option bits of the header, or the default scheme
    always @* begin
        next_use_factory_map    = `FDOD_MAP_RESET; // default includes factory map
        next_skip_certification = 1'b0;
        next_halt_format_flag   = 1'b0;
        if (hdr_fov) begin
            next_use_factory_map    = ~hdr_skipp;
            next_skip_certification = hdr_byte1[`FDOD_HDR_SKIPC_BIT];
            next_halt_format_flag   = hdr_byte1[`FDOD_HDR_HALT_BIT];
        end
    end

    // grown list action from the option field of the command
    always @* begin
        next_use_grown_list = `FDOD_GROWN_RESET;
        next_grown_action   = `FDOD_ACT_KEEP;
        next_hdr_mismatch   = 1'b0;
        case (opt)
            `FDOD_OPT_PROV_ONLY: begin
                // provided list replaces the field-found list
                next_use_grown_list = 1'b0;
                if (hdr_fov && hdr_skipp) begin
                    next_grown_action = `FDOD_ACT_REPLACE;
                end else begin
                    next_grown_action = `FDOD_ACT_REPLACE;
                end
            end
            `FDOD_OPT_PROV_EXIST: begin
                // provided list merged into the existing grown list
                next_use_grown_list = 1'b1;
                if (hdr_fov && hdr_skipp) begin
                    next_grown_action = `FDOD_ACT_MERGE;
                end else begin
                    next_grown_action = `FDOD_ACT_MERGE;
                end
            end
            default: begin
                // option code outside the three handled here
                next_hdr_mismatch = 1'b1;
            end
        endcase
    end

    // --------------------------------------------------------------
    // command capture
    // --------------------------------------------------------------
    // latch option field and command status on each command
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            is_format         <= 1'b0;
            data_out_expected <= 1'b0;
            last_byte_error   <= 1'b0;
            flag_bit          <= 1'b0;
            link_bit          <= 1'b0;
            opt               <= `FDOD_OPT_EXISTING;
        end else if (cmd_valid) begin
            is_format         <= fmt_opcode(cmd_opcode);
            opt               <= cmd_opt;
            // a data-out phase follows a format command unless the lists are kept as they are
            data_out_expected <= cmd_fmt & ~keep_cmd;
            last_byte_error   <= last_bad(cmd_last);
            flag_bit          <= cmd_last[`FDOD_FLAG_BIT];
            link_bit          <= cmd_last[`FDOD_LINK_BIT];
        end
    end

    // --------------------------------------------------------------
    // header decode
    // --------------------------------------------------------------
    // one-cycle strobe for every accepted header
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hdr_done <= 1'b0;
        end else begin
            hdr_done <= hdr_take;
        end
    end

    // option bits held until the next header; a keep command restores the factory map
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            use_factory_map    <= `FDOD_MAP_RESET;
            halt_format_flag   <= 1'b0;
            skip_certification <= 1'b0;
        end else if (hdr_take) begin
            use_factory_map    <= next_use_factory_map;
            halt_format_flag   <= next_halt_format_flag;
            skip_certification <= next_skip_certification;
        end else if (keep_cmd) begin
            use_factory_map    <= `FDOD_MAP_RESET; // factory map stays in use
        end
    end

    // grown list handling held until the next header or keep command
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            use_grown_list <= `FDOD_GROWN_RESET;
            grown_action   <= `FDOD_ACT_KEEP;
            hdr_mismatch   <= 1'b0;
        end else if (hdr_take) begin
            use_grown_list <= next_use_grown_list;
            grown_action   <= next_grown_action;
            hdr_mismatch   <= next_hdr_mismatch;
        end else if (keep_cmd) begin
            use_grown_list <= `FDOD_GROWN_RESET; // grown list kept
            grown_action   <= `FDOD_ACT_KEEP;
            hdr_mismatch   <= 1'b0;
        end
    end

endmodule // fdod_decoder

/* tb/fdod_assertions.sv */
// assertions for the format defect option decoder
// assumes binding to fdod_decoder by port name
`timescale 1ns/1ps
module fdod_checker (
    input wire       ref_clk, arst_n, cmd_valid, hdr_valid, data_out_expected,
    input wire       hdr_done, use_factory_map, halt_format_flag, skip_certification,
    input wire [7:0] cmd_opcode, cmd_byte1, hdr_byte1,
    input wire [1:0] grown_action
);
    reg  [2:0] opt;
    wire       fmt = cmd_valid && cmd_opcode == 8'h04;
    wire       acc = hdr_valid && data_out_expected;
    // option code of the last command
    always @(posedge ref_clk) if (cmd_valid) opt <= cmd_byte1[4:2];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    opt_zero_a: assert property (fmt && cmd_byte1[4:2] == 3'h0 |=>
        !data_out_expected && grown_action == 2'h0) else $error("opt zero");
    hdr_refused_a: assert property (hdr_valid && !data_out_expected |=> !hdr_done)
        else $error("refuse");
    data_phase_a: assert property (fmt |=> data_out_expected == ($past(cmd_byte1[4:2]) != 3'h0))
        else $error("data phase");
    list_replace_a: assert property (acc && opt == 3'h6 |=> hdr_done && grown_action == 2'h1)
        else $error("replace");
    list_merge_a: assert property (acc && opt == 3'h4 |=> grown_action == 2'h2)
        else $error("merge");
    opts_ignored_a: assert property (acc && !hdr_byte1[7] |=> use_factory_map
        && !halt_format_flag && !skip_certification) else $error("invalid opts");
    skip_map_a: assert property (acc && hdr_byte1[7] |=> use_factory_map != $past(hdr_byte1[6]))
        else $error("factory map");
    cover property (acc && opt == 3'h6);
    cover property (acc && opt == 3'h4);
    cover property (hdr_valid && !data_out_expected);
endmodule // fdod_checker
bind fdod_decoder fdod_checker chk (.*);

/* tb/fdod_initiator.sv */
// initiator model: format commands and defect headers
// assumes tasks are entered just after a rising edge
`timescale 1ns/1ps
module fdod_initiator (
    input  wire       ref_clk,
    output reg        cmd_valid = 0,
    output reg  [7:0] cmd_opcode = 0, cmd_byte1 = 0, cmd_last = 0,
    output reg        hdr_valid = 0,
    output reg  [7:0] hdr_byte1 = 0
);
    // command held over one edge, bytes inverted on release
    task send_cmd(input [7:0] op, input [2:0] opt, input [7:0] lst); begin
        {cmd_valid, cmd_opcode, cmd_byte1, cmd_last} = {1'h1, op, 3'h0, opt, 2'h0, lst};
        @(posedge ref_clk) #1 cmd_valid = 0;
        {cmd_opcode, cmd_byte1, cmd_last} = ~{cmd_opcode, cmd_byte1, cmd_last};
    end endtask
    // header byte 1 with reserved bits zero
    task send_hdr(input [3:0] h); begin
        {hdr_valid, hdr_byte1} = {1'h1, h, 4'h0};
        @(posedge ref_clk) #1 hdr_valid = 0;
        hdr_byte1 = ~hdr_byte1;
    end endtask
endmodule // fdod_initiator

/* tb/tb.sv */
// self-checking bench for the format defect option decoder
// assumes the initiator model and the bound checker
`timescale 1ns/1ps
module tb;
    reg        ref_clk = 0, arst_n = 0, dx;
    integer    seed = 32'hD6342A00, n_fail = 0, n_tests = 0, i;
    reg  [7:0] op;
    reg  [2:0] opt;
    reg  [3:0] h;
    reg  [1:0] fl;
    reg  [7:0] lst;
    wire       cv, hv, fm, doe, lbe, fb, lb, dn, ufm, ugl, hlt, skc, mis;
    wire [7:0] co, c1, cl, hb;
    wire [1:0] ga;
    always #2 ref_clk = ~ref_clk;
    fdod_initiator ini (.ref_clk(ref_clk), .cmd_valid(cv), .cmd_opcode(co), .cmd_byte1(c1),
        .cmd_last(cl), .hdr_valid(hv), .hdr_byte1(hb));
    fdod_decoder uut (.ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cv), .cmd_opcode(co),
        .cmd_byte1(c1), .cmd_last(cl), .hdr_valid(hv), .hdr_byte1(hb), .is_format(fm),
        .data_out_expected(doe), .last_byte_error(lbe), .flag_bit(fb), .link_bit(lb),
        .hdr_done(dn), .use_factory_map(ufm), .use_grown_list(ugl), .grown_action(ga),
        .halt_format_flag(hlt), .skip_certification(skc), .hdr_mismatch(mis));
    // compare seen against expected
    task chk(input [31:0] nm, input [7:0] s, input [7:0] e); begin
        n_tests = n_tests + 1;
        if (s !== e) begin
            n_fail = n_fail + 1;
            $display("wrong value %0s expected %h seen %h", nm, e, s);
        end
    end endtask
    task end_sim; begin
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    end endtask
    // random commands over the four option codes, each with a header
    initial begin
        repeat (8) @(posedge ref_clk);
        #1 arst_n = 1;
        for (i = 0; i < 60; i = i + 1) begin
            op = ($random(seed) & 3) ? 8'h04 : 8'h0A;
            opt = i % 4 == 0 ? 3'h0 : i % 4 == 1 ? 3'h6 : i % 4 == 2 ? 3'h4 : 3'h2;
            {h, fl} = $random(seed);
            lst = {6'h00, fl};
            if (i % 5 == 4) lst[7:2] = $random(seed) | 6'h01;
            dx = op == 8'h04 && opt != 3'h0;
            ini.send_cmd(op, opt, lst);
            chk("fmt", fm, op == 8'h04);
            chk("doe", doe, dx);
            chk("last", {lbe, fb, lb}, {|lst[7:2], lst[1:0]});
            if (op == 8'h04 && !dx) chk("keep", {ugl, ga, ufm}, {1'b1, 2'h0, 1'b1});
            ini.send_hdr(h);
            chk("done", dn, dx);
            if (dx) chk("ga", {ugl, ga, mis}, opt == 3'h6 ? {1'b0, 2'h1, 1'b0} :
                opt == 3'h4 ? {1'b1, 2'h2, 1'b0} : {1'b1, 2'h0, 1'b1});
            if (dx) chk("map", {ufm, hlt, skc}, h[3] ? {!h[2], h[0], h[1]} : 3'h4);
            $display("test %0d done", i);
        end
        end_sim;
    end
endmodule // tb
